// ==== tb/bmp_media.sv ====
// media sink model that records extended blocks
`timescale 1ns/100ps

module bmp_media (
  // clock and reset
  input wire       clock,
  input wire       rst,
  // media stream
  input wire       nv_valid,
  output reg       nv_ready,
  input wire [7:0] nv_byte,
  // stall request
  input wire       stall
);
  logic [7:0] got[$];
  logic       fire;
  logic [7:0] b;

  // handshake settled before the edge
  always @(negedge clock) begin
    fire = nv_valid && nv_ready;
    b = nv_byte;
  end

  // slow sink, every other cycle, none while stalled
  always @(posedge clock) begin
    if (fire)
      got.push_back(b);
    nv_ready <= !rst && !stall && !nv_ready;
  end
endmodule // bmp_media

// ==== tb/bmp_props.sv ====
// port checker for the protection stage
`timescale 1ns/100ps

module bmp_props #(
  parameter BLK_BYTES = 512
) (
  // clock and reset
  input wire        clock,
  input wire        rst,
  // format and command
  input wire        fmt_load,
  input wire        fmt_contig,
  input wire [1:0]  fmt_pi_type,
  input wire [1:0]  id_pi_type,
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [15:0] cmd_nblocks,
  // streams and completion
  input wire        hd_ready,
  input wire        hm_ready,
  input wire        nv_valid,
  input wire        nv_ready,
  input wire [7:0]  nv_byte,
  input wire        done_valid,
  input wire [7:0]  done_status
);
  reg contig_r;

  // placement mode as last loaded
  always @(posedge clock) begin
    if (rst)
      contig_r <= 1'b1;
    else if (fmt_load && cmd_ready)
      contig_r <= fmt_contig;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_fmt_id;
    fmt_load && cmd_ready |=> id_pi_type == $past(fmt_pi_type);
  endproperty
  a_fmt_id: assert property (p_fmt_id) else $error("bad type");
  property p_fmt_busy;
    !cmd_ready |=> $stable(id_pi_type);
  endproperty
  a_fmt_busy: assert property (p_fmt_busy) else $error("busy load");
  property p_zero;
    cmd_valid && cmd_ready && cmd_nblocks == 16'h0000
      |-> ##[1:3] done_valid && done_status == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("empty command");
  property p_min;
    cmd_valid && cmd_ready && cmd_nblocks != 16'h0000
      |=> (!cmd_ready && !done_valid) [*8];
  endproperty
  a_min: assert property (p_min) else $error("early end");
  property p_done;
    done_valid |-> done_status <= 8'h03 ##1 !done_valid && cmd_ready;
  endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_hold;
    nv_valid && !nv_ready |=> nv_valid && $stable(nv_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("media byte moved");
  property p_idle;
    cmd_ready |-> !hd_ready && !hm_ready;
  endproperty
  a_idle: assert property (p_idle) else $error("idle pull");
  property p_contig;
    contig_r |-> !hm_ready;
  endproperty
  a_contig: assert property (p_contig) else $error("meta stream");
endmodule // bmp_props

bind bmp_top bmp_props #(.BLK_BYTES(BLK_BYTES)) u_props (
  .clock(clock), .rst(rst), .fmt_load(fmt_load), .fmt_contig(fmt_contig),
  .fmt_pi_type(fmt_pi_type), .id_pi_type(id_pi_type),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_nblocks(cmd_nblocks),
  .hd_ready(hd_ready), .hm_ready(hm_ready), .nv_valid(nv_valid),
  .nv_ready(nv_ready), .nv_byte(nv_byte), .done_valid(done_valid),
  .done_status(done_status)
);

// ==== tb/tb.sv ====
// self-checking bench for the protection stage
`timescale 1ns/100ps

module tb;
  localparam BLK = 16;
  // design inputs and media stall
  reg          clock, rst, fmt_load, fmt_contig, fmt_pi_first, stall;
  reg          cmd_valid, pi_action_bit, hd_valid, hm_valid;
  reg  [1:0]   fmt_pi_type;
  reg  [7:0]   metadata_size, hd_byte, hm_byte;
  reg  [15:0]  cmd_nblocks, cmd_app_tag, cmd_app_mask;
  reg  [31:0]  cmd_ref_tag;
  // design outputs and media ready
  wire         cmd_ready, hd_ready, hm_ready, nv_valid, nv_ready, done_valid;
  wire [1:0]   id_pi_type;
  wire [7:0]   nv_byte, done_status;
  // bench state
  int          miscompares, n_tests, cf_msize, cf_bad;
  logic        cf_contig, cf_first, cf_act, hd_fire, hm_fire;
  logic [1:0]  cf_type;
  logic [15:0] cf_app, cf_mask;
  logic [31:0] cf_ref;
  logic [7:0]  hdq[$], hmq[$], exq[$];

  bmp_top #(.BLK_BYTES(BLK)) DUT (
    .clock(clock), .rst(rst), .fmt_load(fmt_load), .fmt_contig(fmt_contig),
    .fmt_pi_type(fmt_pi_type), .fmt_pi_first(fmt_pi_first),
    .metadata_size(metadata_size), .id_pi_type(id_pi_type),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_nblocks(cmd_nblocks),
    .pi_action_bit(pi_action_bit), .cmd_ref_tag(cmd_ref_tag),
    .cmd_app_tag(cmd_app_tag), .cmd_app_mask(cmd_app_mask),
    .hd_valid(hd_valid), .hd_ready(hd_ready), .hd_byte(hd_byte),
    .hm_valid(hm_valid), .hm_ready(hm_ready), .hm_byte(hm_byte),
    .nv_valid(nv_valid), .nv_ready(nv_ready), .nv_byte(nv_byte),
    .done_valid(done_valid), .done_status(done_status)
  );
  bmp_media u_media (
    .clock(clock), .rst(rst), .nv_valid(nv_valid), .nv_ready(nv_ready),
    .nv_byte(nv_byte), .stall(stall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // host handshakes settled before the edge
  always @(negedge clock) begin
    hd_fire = hd_valid && hd_ready;
    hm_fire = hm_valid && hm_ready;
  end

  // host buffers, released lines show the inverse byte
  always @(posedge clock) begin
    if (hd_fire)
      void'(hdq.pop_front());
    if (hm_fire)
      void'(hmq.pop_front());
    hd_valid <= hdq.size() != 0;
    hd_byte <= hdq.size() != 0 ? hdq[0] : ~hd_byte;
    hm_valid <= hmq.size() != 0;
    hm_byte <= hmq.size() != 0 ? hmq[0] : ~hm_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    int i;
    crc = c ^ {b, 8'h00};
    for (i = 0; i < 8; i++)
      crc = crc[15] ? {crc[14:0], 1'b0} ^ 16'h8bb7 : {crc[14:0], 1'b0};
  endfunction

  task fmt(input logic c, input logic [1:0] t, input logic f, input int m);
    @(posedge clock);
    fmt_load <= 1'b1;
    fmt_contig <= c;
    fmt_pi_type <= t;
    fmt_pi_first <= f;
    metadata_size <= 8'(m);
    {cf_contig, cf_type, cf_first, cf_msize} = {c, t, f, m};
    @(posedge clock);
    fmt_load <= 1'b0;
    @(negedge clock);
    chk(id_pi_type, t);
  endtask

  // one block into host queues and expected media bytes
  task blk(input int i);
    logic [15:0] c;
    logic [63:0] pi;
    logic [7:0]  b, h;
    int          j, k;
    c = 16'h0000;
    for (j = 0; j < BLK; j++) begin
      b = 8'(i * 37 + j * 5 + 3);
      hdq.push_back(b);
      exq.push_back(b);
      c = crc(c, b);
    end
    for (j = 0; j < cf_msize; j++) begin
      k = cf_first ? j : j - cf_msize + 8;
      b = 8'(j + 160);
      h = b;
      if (k >= 0 && k < 8) begin
        pi = {c, cf_app, cf_ref + 32'(cf_type == 2'h3 ? 0 : i)};
        b = pi[63 - 8 * k -: 8];
        h = b ^ {7'h00, k == 2 * cf_bad - 1};
      end else if (k < 0)
        c = crc(c, b);
      exq.push_back(cf_act ? b : h);
      if (!(cf_act && cf_msize == 8) && cf_contig)
        hdq.push_back(h);
      else if (!(cf_act && cf_msize == 8))
        hmq.push_back(h);
    end
  endtask

  task run(input int n, input logic [7:0] st);
    int i;
    for (i = 0; i < n; i++)
      blk(i);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_nblocks <= 16'(n);
    pi_action_bit <= cf_act;
    cmd_ref_tag <= cf_ref;
    cmd_app_tag <= cf_app;
    cmd_app_mask <= cf_mask;
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (i = 0; i < 3000 && done_valid !== 1'b1; i++)
      @(negedge clock);
    chk(done_valid, 1'b1);
    chk(done_status, st);
    for (i = 0; i < 200 && u_media.got.size() < exq.size(); i++)
      @(negedge clock);
    chk(u_media.got.size(), exq.size());
    chk(hdq.size() + hmq.size(), 0);
    for (i = 0; i < exq.size(); i++)
      chk(u_media.got[i], exq[i]);
    u_media.got.delete();
    exq.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // contiguous, stalled media, format load while busy
  task t_contig;
    fmt(1'b1, 2'h1, 1'b0, 8);
    {cf_act, cf_bad, cf_ref, cf_app} = {1'b0, 32'd0, 32'h1000, 16'h1234};
    run(0, 8'h00);
    fork
      run(2, 8'h00);
      begin
        repeat (3) @(posedge clock);
        stall <= 1'b1;
        fmt_load <= 1'b1;
        fmt_pi_type <= 2'h3;
        repeat (40) @(negedge clock);
        chk({hd_ready, nv_valid, id_pi_type}, 4'h5);
        @(posedge clock);
        stall <= 1'b0;
        fmt_load <= 1'b0;
      end
    join
  endtask

  task t_sep_first;
    fmt(1'b0, 2'h2, 1'b1, 16);
    {cf_act, cf_bad, cf_ref, cf_app} = {1'b0, 32'd0, 32'h7, 16'h5a5a};
    run(2, 8'h00);
  endtask

  task t_sep_last;
    int e;
    fmt(1'b0, 2'h1, 1'b0, 16);
    {cf_act, cf_ref, cf_app} = {1'b0, 32'habcd, 16'h0042};
    for (e = 0; e < 4; e++) begin
      cf_bad = e;
      run(2, 8'(e));
    end
    // app tag bit flipped outside the mask must pass
    cf_bad = 2;
    cf_mask = 16'hff00;
    run(2, 8'h00);
    cf_mask = 16'hffff;
  endtask

  task t_gen;
    fmt(1'b1, 2'h1, 1'b1, 8);
    {cf_act, cf_bad, cf_ref, cf_app} = {1'b1, 32'd0, 32'h100, 16'h00c3};
    run(2, 8'h00);
    fmt(1'b0, 2'h2, 1'b0, 16);
    cf_bad = 1;
    run(2, 8'h00);
  endtask

  task t_escape;
    fmt(1'b1, 2'h3, 1'b0, 8);
    {cf_act, cf_bad, cf_ref, cf_app} = {1'b0, 32'd1, 32'hffffffff, 16'hffff};
    run(1, 8'h00);
    fmt(1'b1, 2'h1, 1'b0, 8);
    cf_bad = 3;
    run(1, 8'h00);
    fmt(1'b1, 2'h3, 1'b0, 8);
    {cf_ref, cf_app} = {32'h5, 16'h7777};
    run(1, 8'h00);
    // no protection: bad guard passes unchecked and unchanged
    fmt(1'b1, 2'h0, 1'b0, 8);
    cf_bad = 1;
    run(1, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    {fmt_load, fmt_contig, fmt_pi_first, stall} = 4'h0;
    {cmd_valid, pi_action_bit, hd_valid, hm_valid} = 4'h0;
    {fmt_pi_type, metadata_size, hd_byte, hm_byte} = '0;
    {cmd_nblocks, cmd_app_tag, cmd_ref_tag} = '0;
    cmd_app_mask = 16'hffff;
    cf_mask = 16'hffff;
    miscompares = 0;
    n_tests = 0;
    repeat (19) @(posedge clock);
    @(negedge clock);
    chk({cmd_ready, hd_ready, hm_ready, nv_valid, done_valid}, 32'h10);
    chk({done_status, id_pi_type}, 32'h0);
    @(posedge clock);
    rst <= 1'b0;
    t_contig;
    t_sep_first;
    t_sep_last;
    t_gen;
    t_escape;
    stop_test;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test;
  end
endmodule // tb

// ==== verilog/bmp_crc16.v ====
// byte-serial guard crc register
`timescale 1ns/100ps
`include "bmp_defines.vh"

module bmp_crc16 #(
  parameter [15:0] POLY = `BMP_CRC_POLY,
  parameter [15:0] INIT = `BMP_CRC_INIT
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // control
  input  wire        clear,
  input  wire        enable,
  input  wire [7:0]  byte_in,
  // running value
  output reg  [15:0] crc_r
);

  reg     [15:0] crc_nxt;
  reg            fb;
  integer        i;

  // msb first, no reflection
  always @* begin
    crc_nxt = crc_r;
    fb      = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      fb      = crc_nxt[15] ^ byte_in[i];
      crc_nxt = {crc_nxt[14:0], 1'b0};
      if (fb) begin
        crc_nxt = crc_nxt ^ POLY;
      end
    end
  end

  // clear wins over update
  always @(posedge clock) begin
    if (rst || clear) begin
      crc_r <= INIT;
    end else if (enable) begin
      crc_r <= crc_nxt;
    end
  end

endmodule // bmp_crc16

// ==== verilog/bmp_defines.vh ====
// constants for the block metadata and protection information stage
`ifndef BMP_DEFINES_VH
`define BMP_DEFINES_VH

// protection information size and layout
`define BMP_PI_BYTES     8'h08
`define BMP_PI_GUARD_HI  3'h0
`define BMP_PI_GUARD_LO  3'h1
`define BMP_PI_APP_HI    3'h2
`define BMP_PI_APP_LO    3'h3
`define BMP_PI_REF_B3    3'h4
`define BMP_PI_REF_B2    3'h5
`define BMP_PI_REF_B1    3'h6
`define BMP_PI_REF_B0    3'h7

// guard crc
`define BMP_CRC_POLY     16'h8bb7
`define BMP_CRC_INIT     16'h0000

// protection types, zero means no protection
`define BMP_TYPE_NONE    2'h0
`define BMP_TYPE_1       2'h1
`define BMP_TYPE_2       2'h2
`define BMP_TYPE_3       2'h3

// tag values that switch checking off
`define BMP_APP_ESCAPE   16'hffff
`define BMP_REF_ESCAPE   32'hffffffff

// completion status
`define BMP_ST_OK        8'h00
`define BMP_ST_GUARD     8'h01
`define BMP_ST_APP       8'h02
`define BMP_ST_REF       8'h03

// data path sizes
`define BMP_BLK_BYTES    512
`define BMP_FIFO_DEPTH   4
`define BMP_FIFO_AW      2

`endif

// ==== verilog/bmp_fifo.v ====
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
`include "bmp_defines.vh"

module bmp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `BMP_FIFO_DEPTH,
  parameter AW    = `BMP_FIFO_AW
) (
  // clock and reset
  input  wire             clock,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;

  // honest full and empty
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage
  always @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // pointers and fill level
  always @(posedge clock) begin
    if (rst) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // bmp_fifo

// ==== verilog/bmp_top.v ====
// metadata placement and protection information stage, host to media
//
// How it works
// - contiguous: metadata follows block data directly
// - contiguous: data and metadata share data stream
// - separate: metadata from its own stream
// - placement fixed at format, never mixed
// - protection information lives in metadata field
// - protection info first or last eight bytes
// - placed first: guard covers data only
// - placed last: guard adds preceding metadata
// - guard is sixteen-bit crc over data
// - no ip checksum guard form
// - guard, app tag, ref tag, msb first
// - app tag opaque except escape value
// - ref tag ties block to address
// - types one to three, fixed, reported
// - action clear: pass through, check, report
// - action set, eight bytes: generate, append
`timescale 1ns/100ps
`include "bmp_defines.vh"

module bmp_top #(
  parameter BLK_BYTES = `BMP_BLK_BYTES,
  parameter FIFO_DEPTH = `BMP_FIFO_DEPTH,
  parameter FIFO_AW = `BMP_FIFO_AW
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // namespace format
  input  wire        fmt_load,
  input  wire        fmt_contig,
  input  wire [1:0]  fmt_pi_type,
  input  wire        fmt_pi_first,
  input  wire [7:0]  metadata_size,
  // identification data
  output reg  [1:0]  id_pi_type,
  // command
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [15:0] cmd_nblocks,
  input  wire        pi_action_bit,
  input  wire [31:0] cmd_ref_tag,
  input  wire [15:0] cmd_app_tag,
  input  wire [15:0] cmd_app_mask,
  // host stream at the data pointer
  input  wire        hd_valid,
  output wire        hd_ready,
  input  wire [7:0]  hd_byte,
  // host stream at the metadata pointer
  input  wire        hm_valid,
  output wire        hm_ready,
  input  wire [7:0]  hm_byte,
  // media stream, extended blocks
  output wire        nv_valid,
  input  wire        nv_ready,
  output wire [7:0]  nv_byte,
  // completion
  output reg         done_valid,
  output reg  [7:0]  done_status
);

  ////////////////////////////////////////////////////////////////////////
  // states
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_DATA  = 3'd1;
  localparam [2:0] S_META  = 3'd2;
  localparam [2:0] S_CHECK = 3'd3;
  localparam [2:0] S_DONE  = 3'd4;
  localparam [15:0] BLK_LAST = BLK_BYTES[15:0] - 16'h0001;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;

  // namespace format, held while a command runs
  reg         contig_r;
  reg  [1:0]  type_r;
  reg         first_r;
  reg  [7:0]  msize_r;

  // command context
  reg         act_r;
  reg  [31:0] ref_r;
  reg  [15:0] app_r;
  reg  [15:0] mask_r;
  reg  [15:0] nblk_r;
  reg  [15:0] blk_r;
  reg  [15:0] cnt_r;

  // received protection information and sticky errors
  reg  [63:0] pi_rx_r;
  reg         g_err_r;
  reg         a_err_r;
  reg         r_err_r;

  // data path
  wire        pi_on;
  wire        gen_all;
  wire        in_pi;
  wire [7:0]  pi_start;
  wire [2:0]  pi_k;
  wire        gen_pi;
  wire        src_v;
  wire [7:0]  src_b;
  reg  [7:0]  gen_b;
  wire [7:0]  out_b;
  wire        out_v;
  wire        f_rdy;
  wire        fire;
  wire        crc_en;
  wire        crc_clr;
  wire [15:0] crc_val;
  wire        last_data;
  wire        last_meta;

  // check terms
  wire [15:0] rx_guard;
  wire [15:0] rx_app;
  wire [31:0] rx_ref;
  wire        escape;
  wire        do_check;
  wire        last_blk;

  ////////////////////////////////////////////////////////////////////////
  // format selection
  assign pi_on   = (type_r != `BMP_TYPE_NONE);
  // action set with bare protection info: no metadata taken from host
  assign gen_all = pi_on && act_r && (msize_r == `BMP_PI_BYTES);

  // protection info window inside the metadata field
  assign pi_start = first_r ? 8'h00 : msize_r - `BMP_PI_BYTES;
  assign in_pi    = pi_on && (state_r == S_META) &&
                    (cnt_r[7:0] >= pi_start) &&
                    (cnt_r[7:0] < pi_start + `BMP_PI_BYTES);
  assign pi_k     = cnt_r[2:0] - pi_start[2:0];
  assign gen_pi   = in_pi && act_r;

  assign last_data = (cnt_r == BLK_LAST);
  assign last_meta = (cnt_r[7:0] == msize_r - 8'h01);

  // generated bytes, most significant first
  always @* begin
    case (pi_k)
      `BMP_PI_GUARD_HI: gen_b = crc_val[15:8];
      `BMP_PI_GUARD_LO: gen_b = crc_val[7:0];
      `BMP_PI_APP_HI:   gen_b = app_r[15:8];
      `BMP_PI_APP_LO:   gen_b = app_r[7:0];
      `BMP_PI_REF_B3:   gen_b = ref_r[31:24];
      `BMP_PI_REF_B2:   gen_b = ref_r[23:16];
      `BMP_PI_REF_B1:   gen_b = ref_r[15:8];
      default:          gen_b = ref_r[7:0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // source steering
  // data always from the data pointer; metadata by placement mode
  assign src_v = (state_r == S_DATA) ? hd_valid :
                 contig_r ? hd_valid : hm_valid;
  assign src_b = (state_r == S_DATA) ? hd_byte :
                 contig_r ? hd_byte : hm_byte;

  // metadata bytes either pass or are overwritten by generated info
  assign out_b = gen_pi ? gen_b : src_b;
  assign out_v = ((state_r == S_DATA) && hd_valid) ||
                 ((state_r == S_META) && (gen_all || src_v));
  assign fire  = out_v && f_rdy;

  // ready goes back only to the stream that feeds this byte
  assign hd_ready = f_rdy && ((state_r == S_DATA) ||
                    ((state_r == S_META) && contig_r && !gen_all));
  assign hm_ready = f_rdy && (state_r == S_META) &&
                    !contig_r && !gen_all;
  assign cmd_ready = (state_r == S_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // guard crc: data, plus metadata before a trailing info field
  assign crc_en  = fire && ((state_r == S_DATA) ||
                   ((state_r == S_META) && !first_r && !in_pi));
  assign crc_clr = (state_r == S_IDLE) || (state_r == S_CHECK);

  // only the crc form of the guard exists here
  bmp_crc16 #(
    .POLY (`BMP_CRC_POLY),
    .INIT (`BMP_CRC_INIT)
  ) u_crc (
    .clock   (clock),
    .rst     (rst),
    .clear   (crc_clr),
    .enable  (crc_en),
    .byte_in (src_b),
    .crc_r   (crc_val)
  );

  ////////////////////////////////////////////////////////////////////////
  // output buffer toward the media
  bmp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (out_v),
    .in_ready  (f_rdy),
    .in_data   (out_b),
    .out_valid (nv_valid),
    .out_ready (nv_ready),
    .out_data  (nv_byte)
  );

  ////////////////////////////////////////////////////////////////////////
  // check terms from the received info field
  assign rx_guard = pi_rx_r[63:48];
  assign rx_app   = pi_rx_r[47:32];
  assign rx_ref   = pi_rx_r[31:0];
  // escape values switch checking off for this block
  assign escape   = (type_r == `BMP_TYPE_3) ?
                    ((rx_app == `BMP_APP_ESCAPE) &&
                     (rx_ref == `BMP_REF_ESCAPE)) :
                    (rx_app == `BMP_APP_ESCAPE);
  assign do_check = pi_on && !act_r && !escape &&
                    (msize_r >= `BMP_PI_BYTES);
  assign last_blk = (blk_r + 16'h0001 == nblk_r);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (cmd_valid) begin
          state_nxt = (cmd_nblocks == 16'h0000) ? S_DONE : S_DATA;
        end
      end
      S_DATA: begin
        if (fire && last_data) begin
          state_nxt = (msize_r == 8'h00) ? S_CHECK : S_META;
        end
      end
      S_META: begin
        if (fire && last_meta) begin
          state_nxt = S_CHECK;
        end
      end
      S_CHECK: begin
        state_nxt = last_blk ? S_DONE : S_DATA;
      end
      S_DONE: begin
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // state register
  always @(posedge clock) begin
    if (rst) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // format registers, loaded only between commands
  always @(posedge clock) begin
    if (rst) begin
      contig_r   <= 1'b1;
      type_r     <= `BMP_TYPE_NONE;
      first_r    <= 1'b0;
      msize_r    <= 8'h00;
      id_pi_type <= `BMP_TYPE_NONE;
    end else if (fmt_load && (state_r == S_IDLE)) begin
      contig_r   <= fmt_contig;
      type_r     <= fmt_pi_type;
      first_r    <= fmt_pi_first;
      msize_r    <= metadata_size;
      id_pi_type <= fmt_pi_type;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command context and byte counter
  always @(posedge clock) begin
    if (rst) begin
      act_r  <= 1'b0;
      ref_r  <= 32'h00000000;
      app_r  <= 16'h0000;
      mask_r <= 16'h0000;
      nblk_r <= 16'h0000;
      blk_r  <= 16'h0000;
      cnt_r  <= 16'h0000;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (cmd_valid) begin
            act_r  <= pi_action_bit;
            ref_r  <= cmd_ref_tag;
            app_r  <= cmd_app_tag;
            mask_r <= cmd_app_mask;
            nblk_r <= cmd_nblocks;
            blk_r  <= 16'h0000;
            cnt_r  <= 16'h0000;
          end
        end
        S_DATA, S_META: begin
          if (fire) begin
            cnt_r <= (state_nxt != state_r) ? 16'h0000 : cnt_r + 16'h0001;
          end
        end
        S_CHECK: begin
          // expected reference follows the block address
          if (type_r != `BMP_TYPE_3) begin
            ref_r <= ref_r + 32'h00000001;
          end
          blk_r <= blk_r + 16'h0001;
          cnt_r <= 16'h0000;
        end
        default: begin
          cnt_r <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture the received info field as it passes
  always @(posedge clock) begin
    if (rst) begin
      pi_rx_r <= 64'h0000000000000000;
    end else if (fire && in_pi) begin
      pi_rx_r <= {pi_rx_r[55:0], src_b};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky check errors for the command
  always @(posedge clock) begin
    if (rst || (state_r == S_IDLE)) begin
      g_err_r <= 1'b0;
      a_err_r <= 1'b0;
      r_err_r <= 1'b0;
    end else if ((state_r == S_CHECK) && do_check) begin
      if (rx_guard != crc_val) begin
        g_err_r <= 1'b1;
      end
      // tag compared only under the mask, never interpreted
      if (((rx_app ^ app_r) & mask_r) != 16'h0000) begin
        a_err_r <= 1'b1;
      end
      if ((type_r != `BMP_TYPE_3) && (rx_ref != ref_r)) begin
        r_err_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // completion, guard first then application then reference
  always @(posedge clock) begin
    if (rst) begin
      done_valid  <= 1'b0;
      done_status <= `BMP_ST_OK;
    end else begin
      done_valid <= (state_r == S_DONE);
      if (state_r == S_DONE) begin
        if (g_err_r) begin
          done_status <= `BMP_ST_GUARD;
        end else if (a_err_r) begin
          done_status <= `BMP_ST_APP;
        end else if (r_err_r) begin
          done_status <= `BMP_ST_REF;
        end else begin
          done_status <= `BMP_ST_OK;
        end
      end
    end
  end

endmodule // bmp_top
